/* File: hdl/pbc_base_sel.sv */
/*
  Glitch-free base clock selector with divide-by-two output.
  Assumes source clocks arrive as levels synchronous to the reference clock
  and at most half its rate.
*/
`timescale 1ns/1ns
`default_nettype none

module pbc_base_sel (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  pbc_sel_if.sel sel
);
  import pbc_pkg::*;

  // ----------------------------------------------------------------
  // Edge detection on sampled sources
  // ----------------------------------------------------------------
  logic xc_d_r;
  logic vc_d_r;
  logic x_rise;
  logic v_rise;
  logic old_rise;
  logic old_dead;
  pbc_sel_state_e state_r;
  logic cur_vco_r;
  logic [1:0] cnt_r;
  logic base_r;
  logic cnt_done;

  // Previous samples for rising edges
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      xc_d_r <= 1'b0;
      vc_d_r <= 1'b0;
    end else if (ce_in) begin
      xc_d_r <= sel.crystal_s;
      vc_d_r <= sel.vco_s;
    end
  end

  assign x_rise = sel.crystal_s & ~xc_d_r;
  assign v_rise = sel.vco_s & ~vc_d_r;
  assign old_rise = cur_vco_r ? v_rise : x_rise;
  // A stopped loop never delivers edges; do not wait on it forever
  assign old_dead = cur_vco_r & ~sel.vco_alive;
  assign cnt_done = old_rise && (cnt_r == PBC_SWITCH_EDGES - 2'h1);

  // ----------------------------------------------------------------
  // Transition control
  // ----------------------------------------------------------------
  // Drain three edges of the old source, then three of the new
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= PBC_SEL_RUN;
      cur_vco_r <= PBC_SRC_SEL_RST;
      cnt_r <= 2'h0;
    end else if (ce_in) begin
      case (state_r)
        PBC_SEL_RUN: begin
          cnt_r <= 2'h0;
          if (sel.want_vco != cur_vco_r) begin
            state_r <= PBC_SEL_DRAIN;
          end
        end
        PBC_SEL_DRAIN: begin
          if (cnt_done || old_dead) begin
            state_r <= PBC_SEL_FILL;
            cur_vco_r <= sel.want_vco;
            cnt_r <= 2'h0;
          end else if (old_rise) begin
            cnt_r <= cnt_r + 2'h1;
          end
        end
        PBC_SEL_FILL: begin
          if (cnt_done || old_dead) begin
            state_r <= PBC_SEL_RUN;
            cnt_r <= 2'h0;
          end else if (old_rise) begin
            cnt_r <= cnt_r + 2'h1;
          end
        end
        default: begin
          state_r <= PBC_SEL_RUN;
          cnt_r <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Divide by two
  // ----------------------------------------------------------------
  // Toggling on rising edges only gives 50% duty whatever the source duty
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      base_r <= 1'b0;
    end else if (ce_in) begin
      if (state_r == PBC_SEL_RUN && old_rise) begin
        base_r <= ~base_r;
      end
    end
  end

  // Output held static while not running
  assign sel.busy = (state_r != PBC_SEL_RUN);
  assign sel.using_vco = cur_vco_r;
  assign sel.base_clk = base_r;

endmodule

`default_nettype wire

/* File: hdl/pbc_loop_ctrl.sv */
/*
  Loop bandwidth control, lock indication, lock-change interrupt, programming
  register and protected base clock selection for the clock generator.
  Assumes write/read strobes are one-cycle pulses synchronous to REF_CLK_IN,
  and tolerance comparator levels come from the analog lock detector.
*/
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Self-control mode lets the lock detector pick acquisition or tracking.
// - Self-control: filter mode read-only, set inside tracking, cleared outside untracking.
// - Self-control: lock sets inside lock tolerance, clears outside unlock tolerance.
// - Lock toggle in self-control raises interrupt when lock irq enable is set.
// - Manual mode: filter mode writable, 1 tracking, 0 acquisition.
// - Manual mode disables lock indicator and all interrupts.
// - Program register: multiplier in upper nibble, range in lower nibble.
// - Multiplier zero behaves exactly as one.
// - Range zero disables loop and forces crystal as base source.
// - Source change waits three old and three new edges, output static.
// - Selected source is divided by two for a clean duty cycle.
// - No VCO selection with loop off; no power-off while VCO selected.
// - Power change and source change never take effect in one write.
// - Oscillator and loop run only while oscillator enable is high.
// - Base clock is 50% duty, source clock divided by two.
// - Interrupt output comes from the lock detector.
// - Lock change flag sets on lock toggle, clears on control read.
// - Base source select 1 means VCO, 0 means crystal.
// - Program register writes ignored while loop power is on.
module pbc_loop_ctrl (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic OSC_ENABLE_IN,
  input wire logic CRYSTAL_CLOCK_IN,
  input wire logic VCO_CLOCK_IN,
  input wire logic CTRL_WR_IN,
  input wire logic CTRL_RD_IN,
  input wire logic CTRL_LOOP_POWER_ON_IN,
  input wire logic CTRL_BASE_SOURCE_SELECT_IN,
  input wire logic CTRL_LOCK_IRQ_ENABLE_IN,
  input wire logic BW_WR_IN,
  input wire logic BW_SELF_CONTROL_IN,
  input wire logic BW_FILTER_MODE_IN,
  input wire logic PROG_WR_IN,
  input wire logic [pbc_pkg::PBC_PROG_W-1:0] PROG_DATA_IN,
  input wire logic IN_TRACK_TOL_IN,
  input wire logic OUT_UNTRACK_TOL_IN,
  input wire logic IN_LOCK_TOL_IN,
  input wire logic OUT_UNLOCK_TOL_IN,
  output logic LOOP_POWER_ON_OUT,
  output logic BASE_SOURCE_SELECT_OUT,
  output logic LOCK_IRQ_ENABLE_OUT,
  output logic LOCK_CHANGE_FLAG_OUT,
  output logic BANDWIDTH_SELF_CONTROL_OUT,
  output logic FILTER_MODE_BIT_OUT,
  output logic LOCK_OUT,
  output logic [pbc_pkg::PBC_PROG_W-1:0] LOOP_PROGRAM_REG_OUT,
  output logic [3:0] MULT_N_OUT,
  output logic LOOP_ACTIVE_OUT,
  output logic BASE_SWITCHING_OUT,
  output logic BASE_USING_VCO_OUT,
  output logic BASE_CLOCK_OUT,
  output logic LOCK_CHANGE_IRQ_OUT
);
  import pbc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic power_r;
  logic power_nxt;
  logic src_r;
  logic src_nxt;
  logic auto_r;
  logic man_fm_r;
  logic trk_r;
  logic trk_nxt;
  logic lock_r;
  logic lock_nxt;
  logic ie_r;
  logic flag_r;
  logic [PBC_PROG_W-1:0] prog_r;
  logic range_zero;
  logic loop_active;
  logic pwr_chg;
  logic src_chg;
  logic lock_toggle;

  pbc_sel_if sel_if ();

  // ----------------------------------------------------------------
  // Programming register
  // ----------------------------------------------------------------
  // Frozen while the loop is on so the divider never jumps under it
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      prog_r <= {PBC_MUL_RST, PBC_RNG_RST};
    end else if (CLK_EN_IN) begin
      if (PROG_WR_IN && !power_r) begin
        prog_r <= PROG_DATA_IN;
      end
    end
  end

  assign range_zero = (prog_r[PBC_RNG_MSB:PBC_RNG_LSB] == PBC_FIELD_ZERO);
  // Loop runs only with power, a legal range and the oscillator enabled
  assign loop_active = power_r & ~range_zero & OSC_ENABLE_IN;

  // Effective feedback multiplier
  assign MULT_N_OUT = (prog_r[PBC_MUL_MSB:PBC_MUL_LSB] == PBC_FIELD_ZERO) ?
                      PBC_MUL_ONE : prog_r[PBC_MUL_MSB:PBC_MUL_LSB];

  // ----------------------------------------------------------------
  // Loop power and base source protection
  // ----------------------------------------------------------------
  // A power change wins the write; the source change then waits for a
  // second write, so the VCO is never picked as the loop switches
  always_comb begin
    power_nxt = power_r;
    src_nxt = src_r;
    pwr_chg = (CTRL_LOOP_POWER_ON_IN != power_r) && (CTRL_LOOP_POWER_ON_IN || !src_r);
    src_chg = (CTRL_BASE_SOURCE_SELECT_IN != src_r) && !pwr_chg &&
              (!CTRL_BASE_SOURCE_SELECT_IN || power_r);
    if (CTRL_WR_IN) begin
      if (pwr_chg) begin
        power_nxt = CTRL_LOOP_POWER_ON_IN;
      end else if (src_chg) begin
        src_nxt = CTRL_BASE_SOURCE_SELECT_IN;
      end
    end
    if (range_zero) begin
      src_nxt = 1'b0;
    end
  end

  // Power and source registers
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      power_r <= PBC_LOOP_ON_RST;
      src_r <= PBC_SRC_SEL_RST;
    end else if (CLK_EN_IN) begin
      power_r <= power_nxt;
      src_r <= src_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bandwidth mode and manual filter setting
  // ----------------------------------------------------------------
  // Manual value survives a spell in self-control mode
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      auto_r <= PBC_AUTO_RST;
      man_fm_r <= PBC_FILTER_MODE_RST;
    end else if (CLK_EN_IN) begin
      if (BW_WR_IN) begin
        auto_r <= BW_SELF_CONTROL_IN;
        if (!auto_r) begin
          man_fm_r <= BW_FILTER_MODE_IN;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock detector hysteresis
  // ----------------------------------------------------------------
  // Set and clear thresholds differ, so a marginal VCO does not chatter
  always_comb begin
    trk_nxt = trk_r;
    lock_nxt = lock_r;
    if (!auto_r || !loop_active) begin
      trk_nxt = 1'b0;
      lock_nxt = 1'b0;
    end else begin
      if (IN_TRACK_TOL_IN) begin
        trk_nxt = 1'b1;
      end else if (OUT_UNTRACK_TOL_IN) begin
        trk_nxt = 1'b0;
      end
      if (IN_LOCK_TOL_IN) begin
        lock_nxt = 1'b1;
      end else if (OUT_UNLOCK_TOL_IN) begin
        lock_nxt = 1'b0;
      end
    end
  end

  // Detector registers
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      trk_r <= PBC_FILTER_MODE_RST;
      lock_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      trk_r <= trk_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lock_toggle = auto_r && (lock_nxt != lock_r);

  // ----------------------------------------------------------------
  // Interrupt enable and lock change flag
  // ----------------------------------------------------------------
  // Enable cannot be written and reads zero in manual mode
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      ie_r <= PBC_IE_RST;
    end else if (CLK_EN_IN) begin
      if (!auto_r) begin
        ie_r <= 1'b0;
      end else if (CTRL_WR_IN) begin
        ie_r <= CTRL_LOCK_IRQ_ENABLE_IN;
      end
    end
  end

  // Toggle beats a same-cycle read so no change is lost
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      flag_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (!auto_r) begin
        flag_r <= 1'b0;
      end else if (lock_toggle) begin
        flag_r <= 1'b1;
      end else if (CTRL_RD_IN) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign LOCK_CHANGE_IRQ_OUT = flag_r & ie_r & auto_r;

  // ----------------------------------------------------------------
  // Base clock selector
  // ----------------------------------------------------------------
  // Stopped oscillator or loop presents a flat level to the selector
  assign sel_if.want_vco = src_r;
  assign sel_if.vco_alive = loop_active;
  assign sel_if.crystal_s = CRYSTAL_CLOCK_IN & OSC_ENABLE_IN;
  assign sel_if.vco_s = VCO_CLOCK_IN & loop_active;

  pbc_base_sel u_base_sel (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CLK_EN_IN),
    .sel(sel_if.sel)
  );

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign LOOP_POWER_ON_OUT = power_r;
  assign BASE_SOURCE_SELECT_OUT = src_r;
  assign LOCK_IRQ_ENABLE_OUT = ie_r;
  assign LOCK_CHANGE_FLAG_OUT = flag_r;
  assign BANDWIDTH_SELF_CONTROL_OUT = auto_r;
  assign FILTER_MODE_BIT_OUT = auto_r ? trk_r : man_fm_r;
  assign LOCK_OUT = lock_r;
  assign LOOP_PROGRAM_REG_OUT = prog_r;
  assign LOOP_ACTIVE_OUT = loop_active;
  assign BASE_SWITCHING_OUT = sel_if.busy;
  assign BASE_USING_VCO_OUT = sel_if.using_vco;
  assign BASE_CLOCK_OUT = sel_if.base_clk;

endmodule

`default_nettype wire

/* File: hdl/pbc_pkg.sv */
/*
  Constants shared by the loop bandwidth control and the base clock selector.
  Assumes nothing of its surroundings; holds definitions only.
*/
package pbc_pkg;

  // ----------------------------------------------------------------
  // Programming register layout
  // ----------------------------------------------------------------
  localparam int PBC_PROG_W = 8;
  localparam int PBC_MUL_MSB = 7;
  localparam int PBC_MUL_LSB = 4;
  localparam int PBC_RNG_MSB = 3;
  localparam int PBC_RNG_LSB = 0;
  localparam logic [3:0] PBC_MUL_RST = 4'h6;
  localparam logic [3:0] PBC_RNG_RST = 4'h6;
  localparam logic [3:0] PBC_FIELD_ZERO = 4'h0;
  localparam logic [3:0] PBC_MUL_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Control reset values
  // ----------------------------------------------------------------
  localparam logic PBC_LOOP_ON_RST = 1'b1;
  localparam logic PBC_SRC_SEL_RST = 1'b0;
  localparam logic PBC_AUTO_RST = 1'b0;
  localparam logic PBC_FILTER_MODE_RST = 1'b0;
  localparam logic PBC_IE_RST = 1'b0;

  // ----------------------------------------------------------------
  // Base clock switch timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PBC_SWITCH_EDGES = 2'h3;

  typedef enum logic [1:0] {
    PBC_SEL_RUN = 2'b00,
    PBC_SEL_DRAIN = 2'b01,
    PBC_SEL_FILL = 2'b10
  } pbc_sel_state_e;

endpackage

/* File: hdl/pbc_sel_if.sv */
/*
  Link between the loop control and the base clock selector.
  Assumes both ends run on the same reference clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface pbc_sel_if;
  logic want_vco;
  logic vco_alive;
  logic crystal_s;
  logic vco_s;
  logic busy;
  logic using_vco;
  logic base_clk;

  modport ctl (output want_vco, output vco_alive, output crystal_s, output vco_s,
               input busy, input using_vco, input base_clk);
  modport sel (input want_vco, input vco_alive, input crystal_s, input vco_s,
               output busy, output using_vco, output base_clk);
endinterface

`default_nettype wire

/* File: sim/pbc_clk_src.sv */
/*
  Source clock model standing in for the crystal and the VCO.
  Assumes the bench reference clock; levels change just after its rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module pbc_clk_src (
  input wire logic clk_in,
  input wire logic osc_en_in,
  input wire logic loop_active_in,
  output logic crystal_out,
  output logic vco_out
);
  // ----------------------------------------
  // Source levels
  // ----------------------------------------
  logic [1:0] div_r = 2'h0;

  // Known levels before the first edge
  initial begin
    crystal_out = 1'b0;
    vco_out = 1'b0;
  end

  // Crystal at a quarter, VCO at half the reference; both stand still when disabled
  always @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
    crystal_out <= #1 osc_en_in & div_r[1];
    vco_out <= #1 osc_en_in & loop_active_in & div_r[0];
  end
endmodule

`default_nettype wire

/* File: sim/pbc_loop_ctrl_asserts.sv */
/*
  Concurrent checks on the loop control top ports.
  Assumes one reference clock domain with synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module pbc_loop_ctrl_asserts (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic BW_WR_IN,
  input wire logic PROG_WR_IN,
  input wire logic IN_LOCK_TOL_IN,
  input wire logic LOOP_POWER_ON_OUT,
  input wire logic BASE_SOURCE_SELECT_OUT,
  input wire logic LOCK_IRQ_ENABLE_OUT,
  input wire logic LOCK_CHANGE_FLAG_OUT,
  input wire logic BANDWIDTH_SELF_CONTROL_OUT,
  input wire logic LOCK_OUT,
  input wire logic [pbc_pkg::PBC_PROG_W-1:0] LOOP_PROGRAM_REG_OUT,
  input wire logic LOOP_ACTIVE_OUT,
  input wire logic BASE_SWITCHING_OUT,
  input wire logic BASE_CLOCK_OUT,
  input wire logic LOCK_CHANGE_IRQ_OUT
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  irq_level_a: assert property (LOCK_CHANGE_IRQ_OUT ==
    (LOCK_CHANGE_FLAG_OUT && LOCK_IRQ_ENABLE_OUT && BANDWIDTH_SELF_CONTROL_OUT)) else $error("irq level wrong");
  // One settled manual cycle is allowed before the lock must read clear
  manual_quiet_a: assert property (!BANDWIDTH_SELF_CONTROL_OUT && !$past(BANDWIDTH_SELF_CONTROL_OUT)
    |-> !LOCK_OUT && !LOCK_CHANGE_IRQ_OUT) else $error("lock or irq in manual mode");
  lock_set_a: assert property (BANDWIDTH_SELF_CONTROL_OUT && LOOP_ACTIVE_OUT && IN_LOCK_TOL_IN
    && CLK_EN_IN && !BW_WR_IN |=> LOCK_OUT) else $error("lock did not set");
  flag_toggle_a: assert property (BANDWIDTH_SELF_CONTROL_OUT && $changed(LOCK_OUT)
    |-> ##[0:1] LOCK_CHANGE_FLAG_OUT) else $error("flag missed a lock toggle");
  vco_guard_a: assert property (BASE_SOURCE_SELECT_OUT |-> LOOP_POWER_ON_OUT
    && LOOP_PROGRAM_REG_OUT[3:0] != 4'h0) else $error("vco selected while loop off");
  one_change_a: assert property ($changed(LOOP_POWER_ON_OUT) |-> $stable(BASE_SOURCE_SELECT_OUT))
    else $error("power and source changed together");
  switch_static_a: assert property (BASE_SWITCHING_OUT && $past(BASE_SWITCHING_OUT)
    |-> $stable(BASE_CLOCK_OUT)) else $error("base clock moved while switching");
  prog_frozen_a: assert property (LOOP_POWER_ON_OUT && PROG_WR_IN && CLK_EN_IN
    |=> $stable(LOOP_PROGRAM_REG_OUT)) else $error("program written while loop on");
endmodule

bind pbc_loop_ctrl pbc_loop_ctrl_asserts u_pbc_loop_ctrl_asserts (.REF_CLK_IN, .RST_N_IN, .CLK_EN_IN,
  .BW_WR_IN, .PROG_WR_IN, .IN_LOCK_TOL_IN, .LOOP_POWER_ON_OUT, .BASE_SOURCE_SELECT_OUT, .LOCK_IRQ_ENABLE_OUT,
  .LOCK_CHANGE_FLAG_OUT, .BANDWIDTH_SELF_CONTROL_OUT, .LOCK_OUT, .LOOP_PROGRAM_REG_OUT, .LOOP_ACTIVE_OUT,
  .BASE_SWITCHING_OUT, .BASE_CLOCK_OUT, .LOCK_CHANGE_IRQ_OUT);

`default_nettype wire

/* File: sim/pbc_loop_ctrl_tb_top.sv */
/*
  Self-checking bench for the loop control and base clock selector.
  Assumes the source clock model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module pbc_loop_ctrl_tb_top;
  import pbc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int ACQUIRE_WAIT = 20; // Acquire wait, shortened
  localparam int ALIGN_WAIT = 20; // Align wait, shortened
  logic clk = 0, rst_n = 0, osc = 1, cwr = 0, crd = 0, pwr = 0, src = 0, ie = 0, bwr = 0, bsc = 0, bfm = 0;
  logic pwe = 0, itk = 0, out = 0, ilk = 0, oul = 0, ce = 1, xtal, vco;
  logic [7:0] pd = 8'h00;
  logic o_pwr, o_src, o_ie, o_flag, o_auto, o_fm, o_lock, o_act, o_sw, o_vco, o_bclk, o_irq;
  logic [7:0] o_prog;
  logic [3:0] o_mul;
  int err_count = 0;
  int checks_done = 0;

  pbc_loop_ctrl u_pbc_loop_ctrl (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(ce), .OSC_ENABLE_IN(osc),
    .CRYSTAL_CLOCK_IN(xtal), .VCO_CLOCK_IN(vco), .CTRL_WR_IN(cwr), .CTRL_RD_IN(crd),
    .CTRL_LOOP_POWER_ON_IN(pwr), .CTRL_BASE_SOURCE_SELECT_IN(src), .CTRL_LOCK_IRQ_ENABLE_IN(ie),
    .BW_WR_IN(bwr), .BW_SELF_CONTROL_IN(bsc), .BW_FILTER_MODE_IN(bfm), .PROG_WR_IN(pwe), .PROG_DATA_IN(pd),
    .IN_TRACK_TOL_IN(itk), .OUT_UNTRACK_TOL_IN(out), .IN_LOCK_TOL_IN(ilk), .OUT_UNLOCK_TOL_IN(oul),
    .LOOP_POWER_ON_OUT(o_pwr), .BASE_SOURCE_SELECT_OUT(o_src), .LOCK_IRQ_ENABLE_OUT(o_ie),
    .LOCK_CHANGE_FLAG_OUT(o_flag), .BANDWIDTH_SELF_CONTROL_OUT(o_auto), .FILTER_MODE_BIT_OUT(o_fm),
    .LOCK_OUT(o_lock), .LOOP_PROGRAM_REG_OUT(o_prog), .MULT_N_OUT(o_mul), .LOOP_ACTIVE_OUT(o_act),
    .BASE_SWITCHING_OUT(o_sw), .BASE_USING_VCO_OUT(o_vco), .BASE_CLOCK_OUT(o_bclk), .LOCK_CHANGE_IRQ_OUT(o_irq));

  pbc_clk_src u_pbc_clk_src (.clk_in(clk), .osc_en_in(osc), .loop_active_in(o_act), .crystal_out(xtal),
    .vco_out(vco));

  // Reference clock, 100 ns period
  always #50 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobe for one edge, then an idle edge so strobes never meet in one step
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask

  task automatic ctrl(input logic p, input logic b, input logic e);
    {pwr, src, ie} = {p, b, e};
    pulse(cwr);
  endtask

  task automatic finish_test;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded wait for the selector to settle on the expected source
  task automatic settle(input logic v);
    int i;
    for (i = 0; i < 60 && (o_sw !== 1'b0 || o_vco !== v); i++) tick();
    if (i == 60) begin
      err_count++;
      finish_test();
    end
  endtask

  // Base clock toggles over 40 reference cycles
  task automatic rate(input logic [7:0] exp);
    logic [7:0] n;
    logic last;
    n = 8'h00;
    last = o_bclk;
    repeat (40) begin
      tick();
      if (o_bclk !== last) n++;
      last = o_bclk;
    end
    chk(n, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    chk({o_pwr, o_src, o_ie, o_flag, o_auto, o_fm, o_lock, o_irq},
        {PBC_LOOP_ON_RST, PBC_SRC_SEL_RST, PBC_IE_RST, 1'b0, PBC_AUTO_RST, PBC_FILTER_MODE_RST, 2'b00});
    chk(o_prog, {PBC_MUL_RST, PBC_RNG_RST});
    chk({4'h0, o_mul}, 8'h06);
  endtask

  task automatic s_prog;
    pd = 8'h05;
    pulse(pwe);
    chk(o_prog, 8'h66);
    ctrl(0, 0, 0);
    pulse(pwe);
    chk(o_prog, 8'h05);
    chk({4'h0, o_mul}, 8'h01);
    pd = 8'h30;
    pulse(pwe);
    ctrl(1, 1, 0);
    ctrl(1, 1, 0);
    chk({5'h00, o_pwr, o_src, o_act}, 8'h04);
    ctrl(0, 0, 0);
    pd = 8'h34;
    pulse(pwe);
    chk({4'h0, o_mul}, 8'h03);
  endtask

  task automatic s_source;
    ctrl(0, 1, 0);
    chk({7'h00, o_src}, 8'h00);
    ctrl(1, 1, 0);
    chk({6'h00, o_pwr, o_src}, 8'h02);
    rate(8'd10);
    ctrl(1, 1, 0);
    chk({7'h00, o_src}, 8'h01);
    chk({6'h00, o_sw, o_vco}, 8'h02);
    settle(1'b1);
    rate(8'd20);
    ctrl(0, 1, 0);
    chk({7'h00, o_pwr}, 8'h01);
    ctrl(1, 0, 0);
    chk({6'h00, o_sw, o_vco}, 8'h03);
    settle(1'b0);
    rate(8'd10);
  endtask

  task automatic s_manual;
    ctrl(0, 0, 0);
    {bsc, bfm} = 2'b00;
    pulse(bwr);
    ctrl(1, 0, 1);
    chk({6'h00, o_pwr, o_ie}, 8'h02);
    ilk = 1'b1;
    tick(ACQUIRE_WAIT);
    chk({6'h00, o_lock, o_irq}, 8'h00);
    bfm = 1'b1;
    pulse(bwr);
    chk({7'h00, o_fm}, 8'h01);
    tick(ALIGN_WAIT);
    bfm = 1'b0;
    pulse(bwr);
    chk({7'h00, o_fm}, 8'h00);
    ilk = 1'b0;
  endtask

  task automatic s_auto;
    bsc = 1'b1;
    pulse(bwr);
    ctrl(1, 0, 1);
    chk({4'h0, o_auto, o_ie, o_fm, o_lock}, 8'h0c);
    itk = 1'b1;
    tick();
    itk = 1'b0;
    tick();
    chk({7'h00, o_fm}, 8'h01);
    out = 1'b1;
    tick(2);
    chk({7'h00, o_fm}, 8'h00);
    out = 1'b0;
    ilk = 1'b1;
    tick(2);
    chk({5'h00, o_lock, o_flag, o_irq}, 8'h07);
    pulse(crd);
    chk({5'h00, o_lock, o_flag, o_irq}, 8'h04);
    ctrl(1, 1, 1);
    settle(1'b1);
    {ilk, oul} = 2'b01;
    tick(2);
    chk({5'h00, o_lock, o_flag, o_irq}, 8'h03);
    ctrl(1, 0, 0);
    chk({6'h00, o_flag, o_irq}, 8'h02);
    settle(1'b0);
    {ilk, oul} = 2'b10;
    tick(2);
    osc = 1'b0;
    tick(2);
    chk({6'h00, o_act, o_lock}, 8'h00);
    osc = 1'b1;
    bsc = 1'b0;
    pulse(bwr);
    chk({4'h0, o_auto, o_lock, o_flag, o_irq}, 8'h00);
  endtask

  // Clock enable low freezes every register, the divider included
  task automatic s_clk_en;
    ce = 1'b0;
    ctrl(0, 0, 0);
    rate(8'd0);
    chk({7'h00, o_pwr}, 8'h01);
    ce = 1'b1;
    ctrl(0, 0, 0);
    chk({7'h00, o_pwr}, 8'h00);
  endtask

  // Main sequence: reset held 12 cycles, then every scenario in turn
  initial begin
    tick(12);
    rst_n = 1'b1;
    s_reset();
    s_prog();
    s_source();
    s_manual();
    s_auto();
    s_clk_en();
    finish_test();
  end
endmodule

`default_nettype wire
